/* src/twb_ctrl.sv */
// two-wire bus control: control register, job flag, clock stretch, ack, START and STOP
// assumes the shifter, address, status and data registers live outside on core_clk
`timescale 1ns/10ps
`include "twb_consts.svh"
module twb_ctrl #(
	parameter logic [15:0] CondCycles = 16'(`TWB_COND_CYC)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [5:0] ioAddr,
	input wire logic ioWrEn,
	input wire logic ioRdEn,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	input wire logic globalIntEn,
	input wire logic jobDone,
	input wire logic dataRegWrite,
	input wire logic ackSlot,
	input wire logic addrMatch,
	input wire logic genCallRx,
	input wire logic genCallEnable,
	input wire logic dataRx,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic irqReq,
	output logic ackDrive,
	output logic addrRespond,
	output logic opStart,
	output logic busBusy
);
	import twb_pkg::*;

	logic rstS1_q;
	logic rstS2_q;
	logic busyQ;
	twb_ctl_s s;
	twb_ctl_s n;
	twb_line_if line ();

	// --------------------------------
	// reset release
	// --------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstS1_q <= 1'b0;
			rstS2_q <= 1'b0;
		end else begin
			rstS1_q <= 1'b1;
			rstS2_q <= rstS1_q;
		end
	end

	twb_line_mon u_mon (
		.core_clk(core_clk),
		.rstN(rstS2_q),
		.clkEn(clkEn),
		.sclPin(sclIn),
		.sdaPin(sdaIn),
		.line(line)
	);

	// --------------------------------
	// control logic
	// --------------------------------
	logic wrCtl;
	logic clrFlag;
	logic setFlag;
	logic engSda;

	assign wrCtl = ioWrEn && (ioAddr == `TWB_CTRL_IO_OFFSET);
	assign clrFlag = wrCtl && ioWrData[`TWB_BIT_FLAG] && s.flag;

	always_comb begin
		n = s;
		setFlag = jobDone;
		engSda = 1'b0;
		n.opStart = clrFlag;
		if (wrCtl) begin
			// bit 1 and the collision bit are not writable
			n.ackEn = ioWrData[`TWB_BIT_ACK];
			n.staReq = ioWrData[`TWB_BIT_STA];
			n.stoReq = ioWrData[`TWB_BIT_STO];
			n.ifEn = ioWrData[`TWB_BIT_EN];
			n.intEn = ioWrData[`TWB_BIT_IE];
		end
		if (dataRegWrite) begin
			n.wcFlag = !s.flag;
		end
		case (s.st)
			ENG_IDLE: begin
				n.cnt = '0;
				// nothing launches while software still owns the flag
				if (s.ifEn && !s.flag) begin
					if (s.stoReq) begin
						n.st = ENG_STOP_SETUP;
					end else if (s.staReq) begin
						n.st = ENG_WAIT_FREE;
					end
				end
			end
			ENG_WAIT_FREE: begin
				if (!s.ifEn) begin
					n.st = ENG_IDLE;
				end else if (!line.busy) begin
					n.st = ENG_START_HOLD;
				end
			end
			ENG_START_HOLD: begin
				engSda = 1'b1;
				n.cnt = s.cnt + 16'h0001;
				if (s.cnt == CondCycles - 16'h0001) begin
					setFlag = 1'b1;
					n.st = ENG_IDLE;
				end
			end
			ENG_STOP_SETUP: begin
				engSda = 1'b1;
				if (line.sclIn) begin
					n.cnt = s.cnt + 16'h0001;
				end
				if (s.cnt == CondCycles - 16'h0001) begin
					// the device ends its own stop request
					engSda = 1'b0;
					n.stoReq = 1'b0;
					n.st = ENG_IDLE;
				end
			end
			default: begin
				n.st = ENG_IDLE;
			end
		endcase
		// a set in the cycle of the clearing write wins
		n.flag = (s.flag && !clrFlag) || setFlag;
		n.irq = s.flag && s.intEn && globalIntEn;
		n.sclOe = n.flag && n.ifEn;
		n.addrRespond = s.ifEn && s.ackEn;
		n.ackDrive = ackSlot && s.ifEn && s.ackEn &&
			(addrMatch || (genCallRx && genCallEnable) || dataRx);
		n.sdaOe = engSda || n.ackDrive;
		n.rdData = '0;
		if (ioRdEn && ioAddr == `TWB_CTRL_IO_OFFSET) begin
			n.rdData = {s.flag, s.ackEn, s.staReq, s.stoReq, s.wcFlag, s.ifEn,
				1'b0, s.intEn};
		end
	end

	always_ff @(posedge core_clk or negedge rstS2_q) begin
		if (!rstS2_q) begin
			s <= '{st: ENG_IDLE, cnt: 16'h0000, rdData: `TWB_CTRL_RESET, default: 1'b0};
			busyQ <= 1'b0;
		end else if (clkEn) begin
			s <= n;
			busyQ <= line.busy;
		end
	end

	assign ioRdData = s.rdData;
	assign irqReq = s.irq;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = s.sclOe;
	assign sdaOe = s.sdaOe;
	assign ackDrive = s.ackDrive;
	assign addrRespond = s.addrRespond;
	assign opStart = s.opStart;
	assign busBusy = busyQ;

	// --------------------------------
	// checks
	// --------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstS2_q);

	sequence seqFree;
		s.st == ENG_WAIT_FREE && s.ifEn && !line.busy && clkEn;
	endsequence
	// the data pull shows one cycle after the hold state is entered
	sequence seqHoldLow;
		s.st == ENG_START_HOLD ##1 sdaOe;
	endsequence

	chk_flag_set: assert property (jobDone && clkEn |=> s.flag)
		else $error("job flag not set after job done");
	chk_irq_gate: assert property (clkEn |=> irqReq == $past(s.flag && s.intEn && globalIntEn))
		else $error("interrupt request does not follow its gate");
	chk_scl_stretch: assert property (s.flag && s.ifEn |-> sclOe)
		else $error("clock line released while job flag set");
	chk_flag_clear: assert property (clrFlag && !jobDone && s.st != ENG_START_HOLD && clkEn
		|=> !s.flag && opStart)
		else $error("writing one did not clear the flag and start");
	chk_flag_sticky: assert property (s.flag && !clrFlag |=> s.flag)
		else $error("job flag cleared without a write of one");
	chk_ack_drive: assert property (ackSlot && addrMatch && s.ifEn && s.ackEn && clkEn
		|=> ackDrive && sdaOe)
		else $error("no ACK on own address");
	chk_addr_detach: assert property (!s.ackEn && clkEn |=> !addrRespond && !ackDrive)
		else $error("responding while ack enable is zero");
	chk_start_idle: assert property (seqFree |=> seqHoldLow)
		else $error("START not issued on idle bus");
	chk_start_wait: assert property (s.st == ENG_WAIT_FREE && line.busy |=> !sdaOe || ackDrive)
		else $error("START driven while bus busy");
	chk_wc_flag: assert property (dataRegWrite && !s.flag && clkEn |=> s.wcFlag)
		else $error("write collision not flagged");
	chk_stop_gen: assert property (s.st == ENG_IDLE && s.ifEn && !s.flag && s.stoReq && clkEn
		|=> s.st == ENG_STOP_SETUP ##1 sdaOe)
		else $error("stop request did not start STOP");
	chk_bit1_zero: assert property (ioRdData[1] == 1'b0)
		else $error("bit 1 read back nonzero");
	chk_gc_gate: assert property (ackSlot && genCallRx && !genCallEnable && !addrMatch && !dataRx
		&& clkEn |=> !ackDrive)
		else $error("general call acknowledged while recognition is off");
	chk_launch_gate: assert property (s.st == ENG_IDLE && s.flag && clkEn |=> s.st == ENG_IDLE)
		else $error("operation launched while job flag set");
	chk_stop_done: assert property (s.st == ENG_STOP_SETUP && s.cnt == CondCycles - 16'h0001 && clkEn
		|=> !s.stoReq && (!sdaOe || ackDrive))
		else $error("stop phase did not release data line");

endmodule : twb_ctrl

/* src/twb_consts.svh */
// constants of the two-wire bus control block: offsets, bit positions, timing
// assumes a single 8-bit control register reached on the processor I/O port
`ifndef TWB_CONSTS_SVH
`define TWB_CONSTS_SVH

`define TWB_CTRL_IO_OFFSET 6'h36
`define TWB_CTRL_DATA_ADDR 8'h56
`define TWB_CTRL_RESET 8'h00
`define TWB_BIT_FLAG 7
`define TWB_BIT_ACK 6
`define TWB_BIT_STA 5
`define TWB_BIT_STO 4
`define TWB_BIT_WC 3
`define TWB_BIT_EN 2
`define TWB_BIT_IE 0
`define TWB_CLK_PERIOD_NS 8
`define TWB_T_COND_NS 4000
`define TWB_COND_CYC ((`TWB_T_COND_NS + `TWB_CLK_PERIOD_NS - 1) / `TWB_CLK_PERIOD_NS)

`endif

/* src/twb_pkg.sv */
// types of the two-wire bus control block
// assumes twb_consts.svh supplies the numbers
package twb_pkg;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_WAIT_FREE,
		ENG_START_HOLD,
		ENG_STOP_SETUP
	} twb_eng_e;

	typedef struct packed {
		twb_eng_e st;
		logic [15:0] cnt;
		logic flag;
		logic ackEn;
		logic staReq;
		logic stoReq;
		logic wcFlag;
		logic ifEn;
		logic intEn;
		logic irq;
		logic sclOe;
		logic sdaOe;
		logic ackDrive;
		logic addrRespond;
		logic opStart;
		logic [7:0] rdData;
	} twb_ctl_s;

	typedef struct packed {
		logic sclS1;
		logic sclS2;
		logic sdaS1;
		logic sdaS2;
		logic sclPrev;
		logic sdaPrev;
		logic busy;
		logic startSeen;
		logic stopSeen;
	} twb_mon_s;

endpackage : twb_pkg

/* src/twb_line_if.sv */
// carrier for the synchronised bus line state between monitor and control
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface twb_line_if;
	logic sclIn;
	logic sdaIn;
	logic busy;
	logic startSeen;
	logic stopSeen;
	modport mon (output sclIn, output sdaIn, output busy, output startSeen, output stopSeen);
	modport ctl (input sclIn, input sdaIn, input busy, input startSeen, input stopSeen);
endinterface : twb_line_if

/* src/twb_line_mon.sv */
// line monitor: synchronises clock and data lines, finds START and STOP, tracks busy
// assumes rstN is already released synchronously to core_clk
`timescale 1ns/10ps
module twb_line_mon (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic clkEn,
	input wire logic sclPin,
	input wire logic sdaPin,
	twb_line_if.mon line
);
	import twb_pkg::*;

	twb_mon_s s;
	twb_mon_s n;

	// --------------------------------
	// condition detection
	// --------------------------------
	// only the second stage of each synchroniser is looked at
	always_comb begin
		n = s;
		n.sclS1 = sclPin;
		n.sclS2 = s.sclS1;
		n.sdaS1 = sdaPin;
		n.sdaS2 = s.sdaS1;
		n.sclPrev = s.sclS2;
		n.sdaPrev = s.sdaS2;
		n.startSeen = s.sclS2 && s.sclPrev && s.sdaPrev && !s.sdaS2;
		n.stopSeen = s.sclS2 && s.sclPrev && !s.sdaPrev && s.sdaS2;
		if (n.startSeen) begin
			n.busy = 1'b1;
		end else if (n.stopSeen) begin
			n.busy = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			s <= '{sclS1: 1'b1, sclS2: 1'b1, sdaS1: 1'b1, sdaS2: 1'b1,
				sclPrev: 1'b1, sdaPrev: 1'b1, default: 1'b0};
		end else if (clkEn) begin
			s <= n;
		end
	end

	assign line.sclIn = s.sclS2;
	assign line.sdaIn = s.sdaS2;
	assign line.busy = s.busy;
	assign line.startSeen = s.startSeen;
	assign line.stopSeen = s.stopSeen;

endmodule : twb_line_mon

/* dv/twb_far_end.sv */
// far-end master model: open-drain pulls on the clock and data lines
// assumes a pull-up in the bench, so a released line reads high
`timescale 1ns/10ps
module twb_far_end (
	output logic sclLow,
	output logic sdaLow
);
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// link clock runs only inside a frame, 80 ns period; idle high outside
	task automatic frameOpen();
		sdaLow = 1'b1;
		#40 sclLow = 1'b1;
		repeat (3) begin
			#40 sclLow = 1'b0;
			#40 sclLow = 1'b1;
		end
	endtask : frameOpen
	task automatic frameClose();
		#40 sclLow = 1'b0;
		#40 sdaLow = 1'b0;
	endtask : frameClose
endmodule : twb_far_end

/* dv/tb.sv */
// testbench for the two-wire bus control block, one task per scenario
// assumes a pulled-up wired-and bus shared with the far-end model
`timescale 1ns/10ps
module tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic ioWrEn = 1'b0;
	logic ioRdEn = 1'b0;
	logic [5:0] ioAddr = 6'h36;
	logic [7:0] ioWrData = 8'h00;
	logic [7:0] ioRdData;
	logic [7:0] r;
	logic globalIntEn = 1'b0;
	logic jobDone = 1'b0;
	logic dataRegWrite = 1'b0;
	logic ackSlot = 1'b0;
	logic addrMatch = 1'b0;
	logic genCallRx = 1'b0;
	logic genCallEnable = 1'b1;
	logic dataRx = 1'b0;
	logic sclOut, sclOe, sdaOut, sdaOe, irqReq, ackDrive, addrRespond, opStart, busBusy;
	logic farScl, farSda;
	wire sclIn = ~(sclOe | farScl);
	wire sdaIn = ~(sdaOe | farSda);
	int miscompares = 0;
	int compares = 0;
	// short condition count keeps START and STOP phases brief
	twb_ctrl #(.CondCycles(16'h0004)) u_twb_ctrl (.core_clk(core_clk), .rst_n(rst_n),
		.clkEn(clkEn), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
		.ioWrData(ioWrData), .ioRdData(ioRdData), .globalIntEn(globalIntEn),
		.jobDone(jobDone), .dataRegWrite(dataRegWrite), .ackSlot(ackSlot),
		.addrMatch(addrMatch), .genCallRx(genCallRx), .genCallEnable(genCallEnable),
		.dataRx(dataRx), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .irqReq(irqReq), .ackDrive(ackDrive),
		.addrRespond(addrRespond), .opStart(opStart), .busBusy(busBusy));
	twb_far_end u_twb_far_end (.sclLow(farScl), .sdaLow(farSda));
	initial forever #4 core_clk = ~core_clk;
	task automatic ck(input logic [7:0] got, input logic [7:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : ck
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		ioAddr <= a;
		ioWrData <= d;
		ioWrEn <= 1'b1;
		@(posedge core_clk);
		ioWrEn <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge core_clk);
		ioAddr <= a;
		ioRdEn <= 1'b1;
		@(posedge core_clk);
		ioRdEn <= 1'b0;
		#1 r = ioRdData;
	endtask : rd
	// bounded wait, the line may already be at the level
	task automatic waitSda(input logic v, input string m);
		for (int i = 0; i < 60 && sdaOe !== v; i++) cyc(1);
		ck({7'h00, sdaOe}, {7'h00, v}, m);
	endtask : waitSda
	task automatic ackTry(input logic [2:0] c, input logic e, input string m);
		@(posedge core_clk);
		ackSlot <= 1'b1;
		{addrMatch, genCallRx, dataRx} <= c;
		@(posedge core_clk);
		ackSlot <= 1'b0;
		{addrMatch, genCallRx, dataRx} <= 3'h0;
		#1 ck({7'h00, ackDrive}, {7'h00, e}, m);
	endtask : ackTry
	task automatic tReset();
		rd(6'h36);
		ck(r, 8'h00, "reset value");
		rd(6'h16);
		ck(r, 8'h00, "other offset");
		ck({6'h00, sclOe, sdaOe}, 8'h00, "lines idle");
		ck({6'h00, sclOut, sdaOut}, 8'h00, "open drain low");
		wr(6'h36, 8'h7B);
		rd(6'h36);
		ck(r, 8'h71, "bits 3 and 1 ignored");
		wr(6'h36, 8'h00);
		$display("test reset done");
	endtask : tReset
	task automatic tFlag();
		wr(6'h36, 8'h05);
		@(posedge core_clk);
		globalIntEn <= 1'b1;
		jobDone <= 1'b1;
		@(posedge core_clk);
		jobDone <= 1'b0;
		cyc(3);
		ck({7'h00, sclOe}, 8'h01, "stretch");
		ck({7'h00, irqReq}, 8'h01, "irq");
		wr(6'h36, 8'h05);
		cyc(200);
		rd(6'h36);
		ck(r, 8'h85, "flag kept");
		@(posedge core_clk);
		globalIntEn <= 1'b0;
		cyc(3);
		ck({7'h00, irqReq}, 8'h00, "irq masked");
		wr(6'h36, 8'hC5);
		ck({7'h00, opStart}, 8'h01, "launch");
		rd(6'h36);
		ck(r, 8'h45, "flag cleared");
		ck({7'h00, sclOe}, 8'h00, "clock free");
		@(posedge core_clk);
		dataRegWrite <= 1'b1;
		@(posedge core_clk);
		dataRegWrite <= 1'b0;
		rd(6'h36);
		ck(r & 8'h08, 8'h08, "collision");
		$display("test flag done");
	endtask : tFlag
	task automatic tAck();
		wr(6'h36, 8'h44);
		cyc(2);
		ck({7'h00, addrRespond}, 8'h01, "respond");
		for (int k = 0; k < 3; k++) ackTry(3'h1 << k, 1'b1, "ack cause");
		@(posedge core_clk);
		genCallEnable <= 1'b0;
		ackTry(3'h2, 1'b0, "general call off");
		@(posedge core_clk);
		clkEn <= 1'b0;
		ackTry(3'h1, 1'b0, "frozen");
		@(posedge core_clk);
		clkEn <= 1'b1;
		genCallEnable <= 1'b1;
		wr(6'h36, 8'h04);
		cyc(2);
		ck({7'h00, addrRespond}, 8'h00, "detached");
		ackTry(3'h4, 1'b0, "no ack");
		$display("test ack done");
	endtask : tAck
	task automatic tStartStop();
		wr(6'h36, 8'h24);
		waitSda(1'b1, "start drive");
		cyc(20);
		ck({6'h00, sclOe, busBusy}, 8'h03, "start done");
		rd(6'h36);
		ck(r & 8'hF7, 8'hA4, "start kept");
		wr(6'h36, 8'h94);
		waitSda(1'b1, "stop drive");
		waitSda(1'b0, "stop release");
		cyc(5);
		ck({7'h00, busBusy}, 8'h00, "bus free");
		rd(6'h36);
		ck(r & 8'h10, 8'h00, "stop bit");
		$display("test start stop done");
	endtask : tStartStop
	task automatic tBusy();
		u_twb_far_end.frameOpen();
		cyc(2);
		ck({7'h00, busBusy}, 8'h01, "far busy");
		wr(6'h36, 8'hA4);
		cyc(30);
		ck({7'h00, sdaOe}, 8'h00, "waits");
		u_twb_far_end.frameClose();
		waitSda(1'b1, "start after stop");
		$display("test busy done");
	endtask : tBusy
	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		cyc(4);
		tReset();
		tFlag();
		tAck();
		tStartStop();
		tBusy();
		end_sim();
	end
	// the whole sequence takes well under 2000 cycles
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
endmodule : tb
